// File: logic/acrp_regs_defs.vh
// register offsets, field positions and reset values of the clock, range and power slice
`ifndef ACRP_REGS_DEFS_VH
`define ACRP_REGS_DEFS_VH
`define ACRP_ADDR_W 15
`define ACRP_OFF_CLOCK_NOISE 15'h002B
`define ACRP_OFF_ALIGN_POS0 15'h002C
`define ACRP_OFF_ALIGN_POS1 15'h002D
`define ACRP_OFF_ALIGN_POS2 15'h002E
`define ACRP_OFF_FS_RANGE0 15'h0030
`define ACRP_OFF_FS_RANGE1 15'h0031
`define ACRP_OFF_POWER_MODE_A 15'h0037
`define ACRP_OFF_TIMESTAMP 15'h003B
`define ACRP_OFF_REF_OUTPUT 15'h003C
`define ACRP_RST_CLOCK_NOISE 8'h10
`define ACRP_RST_FULL_SCALE_CODE 16'hA000
`define ACRP_RST_POWER_MODE_A 8'h4B
`define ACRP_RST_TIMESTAMP 8'h00
`define ACRP_RST_REF_OUTPUT 8'h01
`define ACRP_RST_ALIGN_POS 24'h00_0000
`define ACRP_CODE_LOW_POWER 8'h46
`define ACRP_CODE_HIGH_PERF 8'h4B
`define ACRP_BIT_QUIET_DENOISE 2
`define ACRP_BIT_CLOCK_DENOISE 0
`define ACRP_BIT_TS_RECV 0
`define ACRP_BIT_TS_ECL 1
`define ACRP_BIT_REF_OUT 0
`endif

// File: logic/acrp_sync2.v
// two-flop synchroniser for a bus of levels from outside the clock domain
`timescale 1ns/1ps
module acrp_sync2 #(
	parameter WIDTH = 24
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire [WIDTH-1:0] d_in,
	output reg [WIDTH-1:0] q_out
);
	reg [WIDTH-1:0] stage1;
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage1 <= {WIDTH{1'b0}};
			q_out <= {WIDTH{1'b0}};
		end else begin
			stage1 <= d_in;
			q_out <= stage1;
		end
	end
endmodule

// File: logic/acrp_regs.v
// configuration and status register slice reached over a byte-wide register port
`timescale 1ns/1ps
`include "acrp_regs_defs.vh"
module acrp_regs (
	input wire mclk_in,
	input wire rst_n_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [14:0] addr_in,
	input wire [7:0] wdata_in,
	output reg [7:0] rdata_out,
	output reg rvalid_out,
	input wire [23:0] align_edge_position_in,
	input wire pll_enable_in,
	output reg quiet_supply_denoise_enable_out,
	output reg clock_supply_denoise_enable_out,
	output reg [15:0] full_scale_code_out,
	output reg [7:0] power_mode_code_a_out,
	output reg low_power_active_out,
	output reg timestamp_receiver_enable_out,
	output reg timestamp_ecl_mode_enable_out,
	output reg ref_clock_output_enable_out
);
	reg [7:0] clock_noise_control;
	reg [15:0] full_scale_range;
	reg [7:0] power_mode_select_a;
	reg [7:0] timestamp_input_control;
	reg [7:0] ref_output_control;
	wire [23:0] align_edge_position_value;
	reg [23:0] align_prev;
	reg [23:0] align_held;
	reg [7:0] next_rdata;
	reg pll_meta;
	reg pll_sync;
	wire wr_clock_noise;
	wire wr_fs_low;
	wire wr_fs_high;
	wire wr_power_mode_a;
	wire wr_timestamp;
	wire wr_ref_output;

	// one compare serves every write strobe and keeps the offsets in one place
	function addr_hit;
		input strobe;
		input [14:0] addr;
		input [14:0] offset;
		begin
			addr_hit = strobe && (addr == offset);
		end
	endfunction

	// byte lane of a multi-byte register, lowest offset holds bits 7:0
	function [7:0] byte_lane;
		input [23:0] word;
		input [1:0] lane;
		begin
			case (lane)
				2'h0: byte_lane = word[7:0];
				2'h1: byte_lane = word[15:8];
				2'h2: byte_lane = word[23:16];
				default: byte_lane = 8'h00;
			endcase
		end
	endfunction

	// status comes from the alignment detector's domain, so it is synchronised
	acrp_sync2 #(.WIDTH(24)) u_pos_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.d_in(align_edge_position_in),
		.q_out(align_edge_position_value)
	);

	// the word crosses bit by bit, so it is taken only once two samples agree;
	// a position that keeps moving is reported late rather than torn
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			align_prev <= `ACRP_RST_ALIGN_POS;
			align_held <= `ACRP_RST_ALIGN_POS;
		end else begin
			align_prev <= align_edge_position_value;
			if (align_prev == align_edge_position_value) begin
				align_held <= align_prev;
			end
		end
	end

	// no strobe reaches the alignment position bytes, so writes there fall away
	assign wr_clock_noise = addr_hit(wr_en_in, addr_in, `ACRP_OFF_CLOCK_NOISE);
	assign wr_fs_low = addr_hit(wr_en_in, addr_in, `ACRP_OFF_FS_RANGE0);
	assign wr_fs_high = addr_hit(wr_en_in, addr_in, `ACRP_OFF_FS_RANGE1);
	assign wr_power_mode_a = addr_hit(wr_en_in, addr_in, `ACRP_OFF_POWER_MODE_A);
	assign wr_timestamp = addr_hit(wr_en_in, addr_in, `ACRP_OFF_TIMESTAMP);
	assign wr_ref_output = addr_hit(wr_en_in, addr_in, `ACRP_OFF_REF_OUTPUT);

	// reserved bits are stored as written; keeping them at default is the caller's care
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clock_noise_control <= `ACRP_RST_CLOCK_NOISE;
		end else if (wr_clock_noise) begin
			clock_noise_control <= wdata_in;
		end
	end

	// bytes land on their own, so the code passes through a mixed value between writes
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			full_scale_range <= `ACRP_RST_FULL_SCALE_CODE;
		end else begin
			if (wr_fs_low) begin
				full_scale_range[7:0] <= wdata_in;
			end
			if (wr_fs_high) begin
				full_scale_range[15:8] <= wdata_in;
			end
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_mode_select_a <= `ACRP_RST_POWER_MODE_A;
		end else if (wr_power_mode_a) begin
			power_mode_select_a <= wdata_in;
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timestamp_input_control <= `ACRP_RST_TIMESTAMP;
		end else if (wr_timestamp) begin
			timestamp_input_control <= wdata_in;
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ref_output_control <= `ACRP_RST_REF_OUTPUT;
		end else if (wr_ref_output) begin
			ref_output_control <= wdata_in;
		end
	end

	always @* begin
		next_rdata = 8'h00;
		case (addr_in)
			`ACRP_OFF_CLOCK_NOISE: next_rdata = clock_noise_control;
			`ACRP_OFF_ALIGN_POS0: next_rdata = byte_lane(align_held, 2'h0);
			`ACRP_OFF_ALIGN_POS1: next_rdata = byte_lane(align_held, 2'h1);
			`ACRP_OFF_ALIGN_POS2: next_rdata = byte_lane(align_held, 2'h2);
			`ACRP_OFF_FS_RANGE0: next_rdata = byte_lane({8'h00, full_scale_range}, 2'h0);
			`ACRP_OFF_FS_RANGE1: next_rdata = byte_lane({8'h00, full_scale_range}, 2'h1);
			`ACRP_OFF_POWER_MODE_A: next_rdata = power_mode_select_a;
			`ACRP_OFF_TIMESTAMP: next_rdata = timestamp_input_control;
			`ACRP_OFF_REF_OUTPUT: next_rdata = ref_output_control;
			default: next_rdata = 8'h00;
		endcase
	end

	// pll enable is a level from outside this clock, so it passes two flops
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pll_meta <= 1'b0;
			pll_sync <= 1'b0;
		end else begin
			pll_meta <= pll_enable_in;
			pll_sync <= pll_meta;
		end
	end

	// read data holds until the next read, so a slow host may take it late
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= rd_en_in;
			if (rd_en_in) begin
				rdata_out <= next_rdata;
			end
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quiet_supply_denoise_enable_out <= 1'b0;
			clock_supply_denoise_enable_out <= 1'b0;
			full_scale_code_out <= `ACRP_RST_FULL_SCALE_CODE;
			power_mode_code_a_out <= `ACRP_RST_POWER_MODE_A;
			low_power_active_out <= 1'b0;
			timestamp_receiver_enable_out <= 1'b0;
			timestamp_ecl_mode_enable_out <= 1'b0;
			ref_clock_output_enable_out <= 1'b0;
		end else begin
			quiet_supply_denoise_enable_out <=
				clock_noise_control[`ACRP_BIT_QUIET_DENOISE];
			clock_supply_denoise_enable_out <=
				clock_noise_control[`ACRP_BIT_CLOCK_DENOISE];
			full_scale_code_out <= full_scale_range;
			power_mode_code_a_out <= power_mode_select_a;
			// reserved codes are passed on but never flag low power
			low_power_active_out <= (power_mode_select_a == `ACRP_CODE_LOW_POWER);
			timestamp_receiver_enable_out <=
				timestamp_input_control[`ACRP_BIT_TS_RECV];
			timestamp_ecl_mode_enable_out <=
				timestamp_input_control[`ACRP_BIT_TS_ECL];
			ref_clock_output_enable_out <=
				ref_output_control[`ACRP_BIT_REF_OUT] & pll_sync;
		end
	end
endmodule

// File: tb/acrp_regs_assertions.sv
// concurrent checks on the register slice ports
`timescale 1ns/1ps
module acrp_regs_chk (
	input wire mclk_in,
	input wire rst_n_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [14:0] addr_in,
	input wire [7:0] wdata_in,
	input wire [7:0] rdata_out,
	input wire pll_enable_in,
	input wire quiet_supply_denoise_enable_out,
	input wire [15:0] full_scale_code_out,
	input wire [7:0] power_mode_code_a_out,
	input wire low_power_active_out,
	input wire timestamp_receiver_enable_out,
	input wire timestamp_ecl_mode_enable_out,
	input wire ref_clock_output_enable_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	wire w_pm = wr_en_in && addr_in == 15'h0037;
	wire w_fs = wr_en_in && addr_in == 15'h0030;
	wire w_ts = wr_en_in && addr_in == 15'h003B;
	wire w_cn = wr_en_in && addr_in == 15'h002B;
	pm_code_a: assert property (w_pm |=> ##1 power_mode_code_a_out == $past(wdata_in, 2))
		else $error("power code");
	low_pow_a: assert property (low_power_active_out == (power_mode_code_a_out == 8'h46))
		else $error("low power flag");
	fs_low_a: assert property (w_fs |=> ##1 full_scale_code_out[7:0] == $past(wdata_in, 2))
		else $error("range low byte");
	ts_recv_a: assert property (w_ts |=> ##1
		timestamp_receiver_enable_out == $past(wdata_in[0], 2))
		else $error("ts receiver");
	ts_ecl_a: assert property (w_ts |=> ##1
		timestamp_ecl_mode_enable_out == $past(wdata_in[1], 2))
		else $error("ts ecl");
	quiet_dn_a: assert property (w_cn |=> ##1
		quiet_supply_denoise_enable_out == $past(wdata_in[2], 2))
		else $error("quiet denoise");
	ref_off_a: assert property (!pll_enable_in [*3] |=> !ref_clock_output_enable_out)
		else $error("ref out");
	rd_match_a: assert property (rd_en_in && addr_in == 15'h0037 |=>
		rdata_out == power_mode_code_a_out)
		else $error("read back");
	cover property (w_pm ##2 low_power_active_out);
	cover property (ref_clock_output_enable_out);
	cover property (w_ts ##2 timestamp_ecl_mode_enable_out);
endmodule
bind acrp_regs acrp_regs_chk u_chk (
	.mclk_in(mclk_in),
	.rst_n_in(rst_n_in),
	.wr_en_in(wr_en_in),
	.rd_en_in(rd_en_in),
	.addr_in(addr_in),
	.wdata_in(wdata_in),
	.rdata_out(rdata_out),
	.pll_enable_in(pll_enable_in),
	.quiet_supply_denoise_enable_out(quiet_supply_denoise_enable_out),
	.full_scale_code_out(full_scale_code_out),
	.power_mode_code_a_out(power_mode_code_a_out),
	.low_power_active_out(low_power_active_out),
	.timestamp_receiver_enable_out(timestamp_receiver_enable_out),
	.timestamp_ecl_mode_enable_out(timestamp_ecl_mode_enable_out),
	.ref_clock_output_enable_out(ref_clock_output_enable_out)
);

// File: tb/tb.sv
// self-checking bench for the clock, range and power register slice
`timescale 1ns/1ps
module tb;
	logic mclk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0, pll_enable_in = 0;
	logic [14:0] addr_in = 0;
	logic [7:0] wdata_in = 0, rdata_out, power_mode_code_a_out;
	logic [23:0] align_edge_position_in = 24'h12_3456;
	logic [15:0] full_scale_code_out;
	logic rvalid_out, quiet_supply_denoise_enable_out, clock_supply_denoise_enable_out;
	logic low_power_active_out, timestamp_receiver_enable_out, timestamp_ecl_mode_enable_out;
	logic ref_clock_output_enable_out;
	int err_total = 0, compares = 0;
	acrp_regs dut (.*);
	initial forever #2 mclk_in = ~mclk_in;
	task chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk({15'h0000, g}, {15'h0000, e});
	endtask
	// one idle edge between strobes, so a strobe is never set twice in a step
	task wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		wr_en_in <= 1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_en_in <= 0;
	endtask
	task rd(input logic [14:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		rd_en_in <= 1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_en_in <= 0;
		@(negedge mclk_in);
		chk({7'h00, rvalid_out, rdata_out}, {7'h00, 1'b1, e});
	endtask
	task t_reset;
		rd(15'h002B, 8'h10);
		rd(15'h0031, 8'hA0);
		rd(15'h0037, 8'h4B);
		rd(15'h003B, 8'h00);
		rd(15'h003C, 8'h01);
	endtask
	task t_write;
		// calibration, serial link and the other power registers live outside this slice
		wr(15'h0037, 8'h46);
		wr(15'h0030, 8'hFF);
		wr(15'h0031, 8'hFF);
		wr(15'h002B, 8'h15);
		wr(15'h003B, 8'h03);
		wr(15'h002C, 8'h5A);
		repeat (2) @(negedge mclk_in);
		chk1(low_power_active_out, 1);
		chk({8'h00, power_mode_code_a_out}, 16'h0046);
		chk(full_scale_code_out, 16'hFFFF);
		chk1(quiet_supply_denoise_enable_out & clock_supply_denoise_enable_out, 1);
		chk1(timestamp_receiver_enable_out & timestamp_ecl_mode_enable_out, 1);
		rd(15'h002C, 8'h56);
		rd(15'h002D, 8'h34);
		rd(15'h002E, 8'h12);
		rd(15'h0030, 8'hFF);
		rd(15'h7FFF, 8'h00);
		wr(15'h0037, 8'h4B);
		rd(15'h0037, 8'h4B);
	endtask
	// a second reset in mid-run must bring back every default
	task t_again;
		@(posedge mclk_in);
		rst_n_in <= 0;
		@(negedge mclk_in);
		chk(full_scale_code_out, 16'hA000);
		chk({8'h00, power_mode_code_a_out}, 16'h004B);
		chk1(quiet_supply_denoise_enable_out | clock_supply_denoise_enable_out, 0);
		chk1(timestamp_receiver_enable_out | timestamp_ecl_mode_enable_out, 0);
		chk1(low_power_active_out, 0);
		@(posedge mclk_in);
		rst_n_in <= 1;
		t_reset;
	endtask
	task t_ref;
		@(posedge mclk_in);
		pll_enable_in <= 1;
		repeat (4) @(negedge mclk_in);
		chk1(ref_clock_output_enable_out, 1);
		wr(15'h003C, 8'h00);
		repeat (2) @(negedge mclk_in);
		chk1(ref_clock_output_enable_out, 0);
	endtask
	task complete_run;
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk_in);
		rst_n_in <= 1;
		t_reset;
		t_write;
		t_again;
		t_ref;
		complete_run;
	end
	initial begin
		#20000;
		err_total++;
		complete_run;
	end
endmodule
